//--- core/cmc_chg_if.sv
// carrier between the controller and its mismatch detector
`timescale 1ns/1ns
`default_nettype none
interface cmc_chg_if;
    logic q1;
    logic comp_output_bit;
    logic rd;
    logic mismatch;
    logic rise;
    modport ctrl (output q1, output comp_output_bit, output rd, input mismatch, input rise);
    modport det (input q1, input comp_output_bit, input rd, output mismatch, output rise);
endinterface
`default_nettype wire

//--- core/cmc_ctrl.sv
// comparator control, change detection and AHB-Lite registers
// What this block does
// - raw result high when noninverting input higher
// - comparator_on enables comparator, clear powers down
// - channel_select picks inverting input pin
// - ref_select picks reference or pin noninverting
// - pin driven only if enabled, on, output
// - output_pin_enable overrides port latch regardless on
// - internal output latched each instruction cycle
// - polarity_invert inverts the reported result
// - status bit latched each instruction cycle, pin follows unlatched result
// - read latch captures output on control read
// - mismatch latch samples output one clock after each first phase
// - mismatch is latch xor, cleared by read
// - control write also updates read latch
// - change detection ignores output_pin_enable
// - change flag set by mismatch rising edge
// - return to read-latch level drops mismatch, no flag even if cleared
// - software clears flag with 0, 1 sets it
// - interrupt needs all three enables set
// - port read returns 0 for analog pins
// - control 1 holds timer bits, output readback
// - control 0 bit layout, bits 3,1 zero
// - reset turns comparator off, control 1 gate source on
`timescale 1ns/1ns
`default_nettype none
module cmc_ctrl (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic CMP_RAW_IN,
    output logic CMP_POWER_EN,
    output logic CMP_INV_SEL,
    output logic CMP_REF_SEL,
    output logic TIMER_GATE_SRC,
    output logic CMP_SYNC_EN,
    input wire logic [3:0] PORT_IN,
    output logic [3:0] PORT_OUT,
    output logic [3:0] PORT_OE,
    output logic CMP_IRQ
);
    typedef struct packed {
        logic cmp_s1;
        logic cmp_s2;
        logic [3:0] prt_s1;
        logic [3:0] prt_s2;
        logic [1:0] div;
        logic q1;
        logic q1_late;
        logic comp_output_bit;
        logic on;
        logic oe;
        logic pol;
        logic refsel;
        logic chsel;
        logic gsrc;
        logic syncen;
        logic flag;
        logic cie;
        logic pie;
        logic global_irq_en;
        logic [3:0] dir;
        logic [3:0] lat;
        logic [3:0] ans;
        logic pend;
        logic pwr;
        logic phit;
        logic [7:0] pofs;
        logic ready;
        logic [31:0] rdata;
        logic irq;
        logic [3:0] pout;
        logic [3:0] poe;
        logic [3:0] pwr_v;
    } cmc_st_t;

    cmc_st_t st_r;
    cmc_st_t st_nxt;
    cmc_chg_if chg ();
    logic raw;
    logic comp_output_bit_ext;
    logic acc_rd;
    logic acc_wr;
    logic [7:0] wb;
    logic [31:0] rd_v;
    logic ctl0_acc;
    logic flag_wr;

    // raw result from the analog core, forced low while powered down
    assign raw = st_r.on & st_r.cmp_s2;
    // unlatched polarity-adjusted result used by the pin
    assign comp_output_bit_ext = raw ^ st_r.pol;

    // data phase of an accepted transfer, executed while ready is low
    assign acc_rd = st_r.pend & ~st_r.pwr & st_r.phit;
    assign acc_wr = st_r.pend & st_r.pwr & st_r.phit;
    assign wb = HWDATA[7:0];
    // every access of control 0 refreshes the read latch
    assign ctl0_acc = (acc_rd | acc_wr) & (st_r.pofs == cmc_pkg::OFS_CTL0);
    assign flag_wr = acc_wr & (st_r.pofs == cmc_pkg::OFS_FLAGS);

    // mismatch detector fed by the latched internal output
    assign chg.q1 = st_r.q1_late;
    assign chg.comp_output_bit = st_r.comp_output_bit;
    assign chg.rd = ctl0_acc;

    cmc_mismatch u_mm (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .chg(chg)
    );

    // read multiplexer over the register map
    always_comb begin
        rd_v = 32'h0;
        unique case (st_r.pofs)
            cmc_pkg::OFS_CTL0: begin
                rd_v[cmc_pkg::CTL0_ON] = st_r.on;
                rd_v[cmc_pkg::CTL0_COMP_OUTPUT_BIT] = st_r.comp_output_bit;
                rd_v[cmc_pkg::CTL0_OE] = st_r.oe;
                rd_v[cmc_pkg::CTL0_POL] = st_r.pol;
                rd_v[cmc_pkg::CTL0_REF] = st_r.refsel;
                rd_v[cmc_pkg::CTL0_CH] = st_r.chsel;
            end
            cmc_pkg::OFS_CTL1: begin
                rd_v[cmc_pkg::CTL1_SYNC] = st_r.syncen;
                rd_v[cmc_pkg::CTL1_GSRC] = st_r.gsrc;
                rd_v[cmc_pkg::CTL1_COMP_OUTPUT_BIT] = st_r.comp_output_bit;
            end
            cmc_pkg::OFS_FLAGS: begin
                rd_v[cmc_pkg::FLAG_CHG] = st_r.flag;
            end
            cmc_pkg::OFS_ENABLES: begin
                rd_v[cmc_pkg::EN_CHG] = st_r.cie;
            end
            cmc_pkg::OFS_MASTER: begin
                rd_v[cmc_pkg::MST_GLOBAL] = st_r.global_irq_en;
                rd_v[cmc_pkg::MST_PERIPH] = st_r.pie;
            end
            cmc_pkg::OFS_DIR: begin
                rd_v[3:0] = st_r.dir;
            end
            cmc_pkg::OFS_PORT: begin
                rd_v[3:0] = st_r.pwr_v;
            end
            cmc_pkg::OFS_ANALOG_SELECT: begin
                rd_v[3:0] = st_r.ans;
            end
            default: begin
                rd_v = 32'h0;
            end
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;
        // two-flop synchronisers for the analog result and the pins
        st_nxt.cmp_s1 = CMP_RAW_IN;
        st_nxt.cmp_s2 = st_r.cmp_s1;
        st_nxt.prt_s1 = PORT_IN;
        st_nxt.prt_s2 = st_r.prt_s1;
        // instruction cycle divider, q1 is its first phase
        st_nxt.div = (st_r.div == cmc_pkg::INSTR_LAST) ? 2'h0 : st_r.div + 2'h1;
        st_nxt.q1 = (st_r.div == cmc_pkg::INSTR_LAST);
        st_nxt.q1_late = st_r.q1;
        if (st_r.q1) begin
            st_nxt.comp_output_bit = comp_output_bit_ext;
        end
        // pin levels, analog pins read as zero
        st_nxt.pwr_v = st_r.prt_s2 & ~st_r.ans;
        // bus: accept address phase, then one wait cycle for the data phase
        st_nxt.ready = 1'b1;
        st_nxt.pend = 1'b0;
        if (HSEL && HTRANS[1] && HREADY) begin
            st_nxt.pend = 1'b1;
            st_nxt.pwr = HWRITE;
            st_nxt.phit = (HADDR[31:8] == 24'h0);
            st_nxt.pofs = HADDR[7:0];
            st_nxt.ready = 1'b0;
        end
        // read data captured in the data phase, held until the next transfer
        if (st_r.pend) begin
            st_nxt.rdata = st_r.phit ? rd_v : 32'h0;
        end
        // register writes land at the end of the data phase
        if (acc_wr) begin
            unique case (st_r.pofs)
                cmc_pkg::OFS_CTL0: begin
                    st_nxt.on = wb[cmc_pkg::CTL0_ON];
                    st_nxt.oe = wb[cmc_pkg::CTL0_OE];
                    st_nxt.pol = wb[cmc_pkg::CTL0_POL];
                    st_nxt.refsel = wb[cmc_pkg::CTL0_REF];
                    st_nxt.chsel = wb[cmc_pkg::CTL0_CH];
                end
                cmc_pkg::OFS_CTL1: begin
                    st_nxt.syncen = wb[cmc_pkg::CTL1_SYNC];
                    st_nxt.gsrc = wb[cmc_pkg::CTL1_GSRC];
                end
                cmc_pkg::OFS_ENABLES: begin
                    st_nxt.cie = wb[cmc_pkg::EN_CHG];
                end
                cmc_pkg::OFS_MASTER: begin
                    st_nxt.global_irq_en = wb[cmc_pkg::MST_GLOBAL];
                    st_nxt.pie = wb[cmc_pkg::MST_PERIPH];
                end
                cmc_pkg::OFS_DIR: begin
                    st_nxt.dir = wb[3:0];
                end
                cmc_pkg::OFS_PORT: begin
                    st_nxt.lat = wb[3:0];
                end
                cmc_pkg::OFS_ANALOG_SELECT: begin
                    st_nxt.ans = wb[3:0];
                end
                default: begin
                    st_nxt.lat = st_r.lat;
                end
            endcase
        end
        // change flag: edge sets and wins over a software clear
        if (chg.rise || (flag_wr && wb[cmc_pkg::FLAG_CHG])) begin
            st_nxt.flag = 1'b1;
        end else if (flag_wr) begin
            st_nxt.flag = 1'b0;
        end
        // interrupt only with all three enables
        st_nxt.irq = st_r.flag & st_r.cie & st_r.pie & st_r.global_irq_en;
        // port pins, comparator output overrides the latch on its pin
        st_nxt.pout = st_r.lat;
        st_nxt.poe = ~st_r.dir;
        if (st_r.oe) begin
            st_nxt.pout[cmc_pkg::PIN_COMP_OUTPUT_BIT] = st_r.on & comp_output_bit_ext;
        end
    end

    // state register, reset leaves the comparator off
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            st_r <= '0;
            st_r.on <= cmc_pkg::RST_CTL0[cmc_pkg::CTL0_ON];
            st_r.gsrc <= cmc_pkg::RST_GSRC;
            st_r.syncen <= cmc_pkg::RST_SYNC;
            st_r.dir <= cmc_pkg::RST_DIR;
            st_r.ans <= cmc_pkg::RST_ANALOG_SELECT;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register, HRESP tied low
    assign HREADYOUT = st_r.ready;
    assign HRDATA = st_r.rdata;
    assign HRESP = 1'b0;
    assign CMP_POWER_EN = st_r.on;
    assign CMP_INV_SEL = st_r.chsel;
    assign CMP_REF_SEL = st_r.refsel;
    assign TIMER_GATE_SRC = st_r.gsrc;
    assign CMP_SYNC_EN = st_r.syncen;
    assign PORT_OUT = st_r.pout;
    assign PORT_OE = st_r.poe;
    assign CMP_IRQ = st_r.irq;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    chk_irq_gate: assert property (##1 CMP_IRQ == $past(st_r.flag & st_r.cie & st_r.pie & st_r.global_irq_en))
        else $error("interrupt does not follow flag and enables");
    chk_flag_set: assert property (chg.rise |=> st_r.flag)
        else $error("change edge did not set the flag");
    chk_flag_clear: assert property (flag_wr && !wb[cmc_pkg::FLAG_CHG] && !chg.rise |=> !st_r.flag)
        else $error("software clear of flag ignored");
    chk_flag_swset: assert property (flag_wr && wb[cmc_pkg::FLAG_CHG] |=> st_r.flag)
        else $error("software set of flag ignored");
    chk_pin_drive: assert property (st_r.oe && st_r.on |=> PORT_OUT[cmc_pkg::PIN_COMP_OUTPUT_BIT] == $past(comp_output_bit_ext))
        else $error("pin does not carry comparator output");
    chk_pin_off: assert property (st_r.oe && !st_r.on |=> !PORT_OUT[cmc_pkg::PIN_COMP_OUTPUT_BIT])
        else $error("pin driven while comparator off");
    chk_pin_latch: assert property (!st_r.oe |=>
        PORT_OUT[cmc_pkg::PIN_COMP_OUTPUT_BIT] == $past(st_r.lat[cmc_pkg::PIN_COMP_OUTPUT_BIT]))
        else $error("port latch not shown on pin");
    chk_comp_output_bit_hold: assert property (!st_r.q1 |=> $stable(st_r.comp_output_bit))
        else $error("internal output moved outside first phase");
    chk_comp_output_bit_pol: assert property (st_r.q1 |=> st_r.comp_output_bit == $past(raw ^ st_r.pol))
        else $error("polarity not applied to output");
    chk_status_bit: assert property (acc_rd && st_r.pofs == cmc_pkg::OFS_CTL0 |=> HRDATA[6] == $past(st_r.comp_output_bit))
        else $error("status bit differs from output");
    chk_ctl0_rsvd: assert property (acc_rd && st_r.pofs == cmc_pkg::OFS_CTL0 |=>
        HRDATA[3] == 1'b0 && HRDATA[1] == 1'b0)
        else $error("unimplemented control bits read nonzero");
    chk_analog_zero: assert property (acc_rd && st_r.pofs == cmc_pkg::OFS_PORT |=>
        (HRDATA[3:0] & $past(st_r.ans)) == 4'h0)
        else $error("analog pin read as nonzero");
    chk_ready_wait: assert property (HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 HREADYOUT)
        else $error("slave wait state wrong");

    // bus answers and register map
    chk_ready_idle: assert property (!HSEL |=> HREADYOUT)
        else $error("wait state without a transfer");
    chk_rdata_hold: assert property (!st_r.pend |=> $stable(HRDATA))
        else $error("read data moved outside a data phase");
    chk_unmapped_zero: assert property (st_r.pend && !st_r.phit |=> HRDATA == 32'h0)
        else $error("unmapped address read nonzero");
    chk_ctl0_upper: assert property (acc_rd && st_r.pofs == cmc_pkg::OFS_CTL0 |=> HRDATA[31:8] == 24'h0)
        else $error("upper control bits read nonzero");
    chk_ctl1_comp_output_bit: assert property (acc_rd && st_r.pofs == cmc_pkg::OFS_CTL1 |=>
        HRDATA[cmc_pkg::CTL1_COMP_OUTPUT_BIT] == $past(st_r.comp_output_bit))
        else $error("control 1 readback differs from output");
    chk_on_write: assert property (acc_wr && st_r.pofs == cmc_pkg::OFS_CTL0 |=>
        CMP_POWER_EN == $past(wb[cmc_pkg::CTL0_ON]))
        else $error("enable write not applied");
    chk_sel_write: assert property (acc_wr && st_r.pofs == cmc_pkg::OFS_CTL0 |=>
        CMP_INV_SEL == $past(wb[cmc_pkg::CTL0_CH]) && CMP_REF_SEL == $past(wb[cmc_pkg::CTL0_REF]))
        else $error("input select write not applied");
    chk_lat_write: assert property (acc_wr && st_r.pofs == cmc_pkg::OFS_PORT |=> st_r.lat == $past(wb[3:0]))
        else $error("port latch write not applied");
    chk_pin_oe: assert property (##1 PORT_OE == ~$past(st_r.dir))
        else $error("pin enables do not follow direction");

    // comparator path
    chk_q1_period: assert property (st_r.q1 |=> !st_r.q1 [*3] ##1 st_r.q1)
        else $error("first phase not once per instruction cycle");
    chk_off_output: assert property (!st_r.on && st_r.q1 |=> st_r.comp_output_bit == $past(st_r.pol))
        else $error("output of disabled comparator not forced");

    // change flag and interrupt
    chk_flag_hold: assert property (!chg.rise && !flag_wr |=> $stable(st_r.flag))
        else $error("flag moved without edge or write");
    chk_irq_enables: assert property (CMP_IRQ |-> $past(st_r.cie && st_r.pie && st_r.global_irq_en))
        else $error("interrupt raised with an enable clear");

    cov_flag_set: cover property (chg.rise ##1 st_r.flag);
    cov_sw_set: cover property (flag_wr && wb[cmc_pkg::FLAG_CHG]);
    cov_irq: cover property (CMP_IRQ);
    cov_pin_override: cover property (st_r.oe && st_r.on && !st_r.dir[cmc_pkg::PIN_COMP_OUTPUT_BIT]);
    cov_read_clear: cover property (chg.mismatch && ctl0_acc ##1 !chg.mismatch);
endmodule
`default_nettype wire

//--- core/cmc_mismatch.sv
// two-latch mismatch detector with edge output
`timescale 1ns/1ns
`default_nettype none
module cmc_mismatch (
    input wire logic clk,
    input wire logic rst_n,
    cmc_chg_if.det chg
);
    typedef struct packed {
        logic rd_lat;
        logic q1_lat;
        logic prev;
    } cmc_mm_st_t;
    cmc_mm_st_t st_r;
    cmc_mm_st_t st_nxt;
    logic mm;

    // exclusive-or of the two latches
    assign mm = st_r.rd_lat ^ st_r.q1_lat;
    assign chg.mismatch = mm;
    assign chg.rise = mm & ~st_r.prev;

    // latch updates on control 0 access and one clock after the first phase
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = mm;
        if (chg.rd) begin
            st_nxt.rd_lat = chg.comp_output_bit;
        end
        if (chg.q1) begin
            st_nxt.q1_lat = chg.comp_output_bit;
        end
    end

    // state register, both latches equal after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_read_clears: assert property (chg.rd && chg.comp_output_bit == st_r.q1_lat |=> !mm)
        else $error("mismatch survived a register access");
    chk_no_level_set: assert property (chg.rise |-> mm && !$past(mm))
        else $error("change edge raised by mismatch level");
    chk_q1_sample: assert property (chg.q1 |=> st_r.q1_lat == $past(chg.comp_output_bit))
        else $error("mismatch latch missed first phase sample");
endmodule
`default_nettype wire

//--- core/cmc_pkg.sv
// shared constants for the comparator control block
package cmc_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_ENABLES = 8'h0c;
    localparam logic [7:0] OFS_MASTER = 8'h10;
    localparam logic [7:0] OFS_DIR = 8'h14;
    localparam logic [7:0] OFS_PORT = 8'h18;
    localparam logic [7:0] OFS_ANALOG_SELECT = 8'h1c;
    // comp_control_0 field positions
    localparam int CTL0_ON = 7;
    localparam int CTL0_COMP_OUTPUT_BIT = 6;
    localparam int CTL0_OE = 5;
    localparam int CTL0_POL = 4;
    localparam int CTL0_REF = 2;
    localparam int CTL0_CH = 0;
    // comp_control_1 field positions
    localparam int CTL1_SYNC = 0;
    localparam int CTL1_GSRC = 1;
    localparam int CTL1_COMP_OUTPUT_BIT = 2;
    // flag, enable and master bits
    localparam int FLAG_CHG = 3;
    localparam int EN_CHG = 3;
    localparam int MST_GLOBAL = 7;
    localparam int MST_PERIPH = 6;
    // general port layout
    localparam int PORT_W = 4;
    localparam int PIN_COMP_OUTPUT_BIT = 2;
    // values after reset
    localparam logic [7:0] RST_CTL0 = 8'h00;
    localparam logic RST_GSRC = 1'b1;
    localparam logic RST_SYNC = 1'b0;
    localparam logic [3:0] RST_DIR = 4'hf;
    localparam logic [3:0] RST_ANALOG_SELECT = 4'hf;
    // last divider count, four system clocks per instruction cycle
    localparam logic [1:0] INSTR_LAST = 2'h3;
endpackage

//--- core/dummy_none.sv
// holds no logic; the comparator block lives in the other core files
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- test/cmc_analog_model.sv
// behavioural analog front end that feeds the comparator core
`timescale 1ns/1ns
`default_nettype none
module cmc_analog_model (
    input wire logic pwr_en,
    input wire logic inv_sel,
    input wire logic ref_sel,
    input wire logic [7:0] v_p0,
    input wire logic [7:0] v_p1,
    input wire logic [7:0] v_ref,
    input wire logic [7:0] v_ni,
    output logic raw
);
    logic [7:0] v_inv;
    logic [7:0] v_pos;
    // input muxes pick the inverting pin and the noninverting source
    assign v_inv = inv_sel ? v_p1 : v_p0;
    assign v_pos = ref_sel ? v_ref : v_ni;
    // unpowered core rests low, else high while plus side is above minus
    assign raw = pwr_en && (v_pos > v_inv);
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic hready, hresp, raw, pwr, isel, rsel, gsrc, sync, irq;
    logic [3:0] pout, poe, pins;
    logic [3:0] pext = 4'h0;
    logic [7:0] vni = 8'h20;
    int errors = 0;
    int n_tests = 0;
    // half period of the 50 ns system clock
    always #25 clk = ~clk;
    // pin level: device drive where enabled, else the outside value
    assign pins = (poe & pout) | (~poe & pext);
    cmc_ctrl dut (.CLK_SYS(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
        .CMP_RAW_IN(raw), .CMP_POWER_EN(pwr), .CMP_INV_SEL(isel),
        .CMP_REF_SEL(rsel), .TIMER_GATE_SRC(gsrc), .CMP_SYNC_EN(sync),
        .PORT_IN(pins), .PORT_OUT(pout), .PORT_OE(poe), .CMP_IRQ(irq));
    cmc_analog_model am (.pwr_en(pwr), .inv_sel(isel), .ref_sel(rsel),
        .v_p0(8'h10), .v_p1(8'h30), .v_ref(8'h40), .v_ni(vni), .raw(raw));
    // summary line, verdict and end of run
    task automatic give_verdict();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one comparison, reported at once on a miss
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // wait for hready sampled high at a rising edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
    endtask
    // single ahb-lite word transfer; read data lands in q
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    // register values after reset, unmapped offset reads zero
    task automatic t_reset();
        xfer(0, cmc_pkg::OFS_CTL0, 0);
        chk("ctl0", 32'h0, q);
        xfer(0, cmc_pkg::OFS_CTL1, 0);
        chk("ctl1", 32'h2, q);
        chk("gsrc", 32'h1, {31'h0, gsrc});
        chk("sync", 32'h0, {31'h0, sync});
        chk("hresp", 32'h0, {31'h0, hresp});
        xfer(1, cmc_pkg::OFS_CTL1, 32'h1);
        xfer(0, cmc_pkg::OFS_CTL1, 0);
        chk("ctl1 wr", 32'h1, q);
        chk("timer bits", 32'h1, {30'h0, gsrc, sync});
        xfer(1, cmc_pkg::OFS_CTL1, 32'h2);
        xfer(0, cmc_pkg::OFS_DIR, 0);
        chk("dir", 32'hf, q);
        xfer(0, 8'h20, 0);
        chk("unmapped", 32'h0, q);
        chk("power", 32'h0, {31'h0, pwr});
    endtask
    // enable, channel, reference and polarity against the reported output
    task automatic t_compare();
        logic [7:0] c [7] = '{8'h80, 8'h80, 8'h90, 8'h81, 8'h84, 8'h00, 8'h10};
        logic [7:0] v [7] = '{8'h20, 8'h05, 8'h20, 8'h20, 8'h05, 8'h20, 8'h20};
        logic e [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            vni <= v[i];
            xfer(1, cmc_pkg::OFS_CTL0, {24'h0, c[i] | 8'h0a});
            repeat (8) @(posedge clk);
            xfer(0, cmc_pkg::OFS_CTL0, 0);
            chk("ctl0 out", {24'h0, c[i] | {1'b0, e[i], 6'h0}}, q);
            xfer(0, cmc_pkg::OFS_CTL1, 0);
            chk("ctl1 out", {29'h0, e[i], 2'h2}, q);
            chk("power", {31'h0, c[i][7]}, {31'h0, pwr});
        end
    endtask
    // output pin override and drive conditions
    task automatic t_pin();
        logic [7:0] c [4] = '{8'h80, 8'hb0, 8'h20, 8'ha0};
        logic e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        vni <= 8'h20;
        xfer(1, cmc_pkg::OFS_DIR, 32'hb);
        xfer(1, cmc_pkg::OFS_PORT, 32'h4);
        chk("oe", 32'h4, {28'h0, poe});
        for (int i = 0; i < 4; i++) begin
            xfer(1, cmc_pkg::OFS_CTL0, {24'h0, c[i]});
            repeat (8) @(posedge clk);
            chk("pin", {31'h0, e[i]}, {31'h0, pout[2]});
        end
        xfer(1, cmc_pkg::OFS_DIR, 32'hf);
        repeat (2) @(posedge clk);
        chk("oe off", 32'h0, {28'h0, poe});
    endtask
    // set vni, let it settle, then compare the change flag
    task automatic step(input logic [7:0] nv, input logic [31:0] e);
        vni <= nv;
        repeat (10) @(posedge clk);
        xfer(0, cmc_pkg::OFS_FLAGS, 0);
        chk("flag", e, q);
    endtask
    // change detection, edge behaviour and interrupt gating
    task automatic t_change();
        xfer(1, cmc_pkg::OFS_ENABLES, 32'h8);
        xfer(1, cmc_pkg::OFS_CTL0, 32'h80);
        repeat (10) @(posedge clk);
        xfer(1, cmc_pkg::OFS_FLAGS, 0);
        xfer(0, cmc_pkg::OFS_CTL0, 0);
        step(8'h20, 32'h0);
        step(8'h05, 32'h8);
        chk("irq gated", 32'h0, {31'h0, irq});
        xfer(1, cmc_pkg::OFS_FLAGS, 0);
        step(8'h20, 32'h0);
        step(8'h05, 32'h8);
        xfer(1, cmc_pkg::OFS_CTL0, 32'h80);
        xfer(1, cmc_pkg::OFS_FLAGS, 0);
        step(8'h20, 32'h8);
        xfer(1, cmc_pkg::OFS_MASTER, 32'hc0);
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1, cmc_pkg::OFS_FLAGS, 0);
        repeat (3) @(posedge clk);
        chk("irq clr", 32'h0, {31'h0, irq});
        xfer(1, cmc_pkg::OFS_FLAGS, 32'h8);
        repeat (3) @(posedge clk);
        chk("irq sw", 32'h1, {31'h0, irq});
        xfer(1, cmc_pkg::OFS_MASTER, 32'h40);
        repeat (3) @(posedge clk);
        chk("irq nogie", 32'h0, {31'h0, irq});
    endtask
    // analog pins read back as zero on the general port
    task automatic t_port();
        pext <= 4'hf;
        repeat (4) @(posedge clk);
        xfer(0, cmc_pkg::OFS_PORT, 0);
        chk("port all analog", 32'h0, q);
        xfer(1, cmc_pkg::OFS_ANALOG_SELECT, 32'h3);
        xfer(0, cmc_pkg::OFS_PORT, 0);
        chk("port mixed", 32'hc, q);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_compare();
        t_pin();
        t_change();
        t_port();
        give_verdict();
    end
endmodule
`default_nettype wire
